/* File: loop_cfg_params.svh */
`ifndef LOOP_CFG_PARAMS_SVH
`define LOOP_CFG_PARAMS_SVH
`define ALT_CFG_OFFSET 8'hac
`define LOOP_CFG_OFFSET 8'had
`define ALT_GAIN_MSB 7
`define ALT_GAIN_LSB 6
`define ALT_TIME_MSB 5
`define ALT_TIME_LSB 3
`define ALT_RAMP_MSB 2
`define ALT_RAMP_LSB 0
`define LOOP_RSVD_BIT 7
`define SS_DCM_BIT 6
`define NOC_TON_BIT 5
`define IND_MSB 4
`define IND_LSB 3
`define DC_LOAD_LINE_SEL_MSB 2
`define DC_LOAD_LINE_SEL_LSB 0
`define ALT_CFG_RESET 8'h00
`define LOOP_CFG_RESET 8'h00
`define LOOP_WRITE_MASK 8'h7f
`define NOC_SHORT_5MV_MV 12'h258
`define NOC_LONG_5MV_MV 12'h640
`define NOC_SHORT_10MV_MV 12'h4b0
`define NOC_LONG_10MV_MV 12'hc80
`endif

/* File: loop_cfg_pkg.sv */
package loop_cfg_pkg;
  // whole register-bank state, registered as one word
  typedef struct packed {
    logic [7:0] alt_cfg;
    logic [7:0] loop_cfg;
    logic [7:0] rd_data;
    logic rd_valid;
    logic cmd_ack;
    logic ss_dcm_force;
    logic forced_continuous_conduction;
    logic [11:0] noc_numer_mv;
    logic [8:0] ind_nh;
    logic [12:0] dc_load_line_sel_uohm;
    logic [3:0] alt_gain_x4;
    logic [14:0] alt_time_ns;
    logic [7:0] alt_ramp_mv;
  } cfg_state_t;
endpackage

/* File: loop_setting_decode.sv */
`timescale 1ns/100ps
`include "loop_cfg_params.svh"
module loop_setting_decode (
  input wire logic [7:0] alt_cfg_in,
  input wire logic [7:0] loop_cfg_in,
  input wire logic [1:0] vid_protocol_identifier_in,
  output logic [11:0] noc_numer_mv_out,
  output logic [8:0] ind_nh_out,
  output logic [12:0] dc_load_line_sel_uohm_out,
  output logic [3:0] alt_gain_x4_out,
  output logic [14:0] alt_time_ns_out,
  output logic [7:0] alt_ramp_mv_out
);
  logic step_5mv;
  logic short_ton;

  // protocol 01b/10b means 5 mv output steps
  assign step_5mv = vid_protocol_identifier_in[1] ^ vid_protocol_identifier_in[0];
  assign short_ton = loop_cfg_in[`NOC_TON_BIT];

  // negative-current on-time numerator in mv
  always_comb begin
    if (step_5mv) begin
      noc_numer_mv_out = short_ton ? `NOC_SHORT_5MV_MV : `NOC_LONG_5MV_MV;
    end else begin
      noc_numer_mv_out = short_ton ? `NOC_SHORT_10MV_MV : `NOC_LONG_10MV_MV;
    end
  end

  // inductor for current sensing, nh
  always_comb begin
    case (loop_cfg_in[`IND_MSB:`IND_LSB])
      2'h0: ind_nh_out = 9'h064;
      2'h1: ind_nh_out = 9'h0c8;
      2'h2: ind_nh_out = 9'h12c;
      default: ind_nh_out = 9'h190;
    endcase
  end

  // dc load line in micro-ohm, zero is flat regulation
  always_comb begin
    case (loop_cfg_in[`DC_LOAD_LINE_SEL_MSB:`DC_LOAD_LINE_SEL_LSB])
      3'h0: dc_load_line_sel_uohm_out = 13'h0000;
      3'h1: dc_load_line_sel_uohm_out = 13'h01f4;
      3'h2: dc_load_line_sel_uohm_out = 13'h02ee;
      3'h3: dc_load_line_sel_uohm_out = 13'h03e8;
      3'h4: dc_load_line_sel_uohm_out = 13'h05dc;
      3'h5: dc_load_line_sel_uohm_out = 13'h0b54;
      3'h6: dc_load_line_sel_uohm_out = 13'h0c80;
      default: dc_load_line_sel_uohm_out = 13'h0fd2;
    endcase
  end

  // alternate fields, informational only
  always_comb begin
    case (alt_cfg_in[`ALT_GAIN_MSB:`ALT_GAIN_LSB])
      2'h0: alt_gain_x4_out = 4'h8;
      2'h1: alt_gain_x4_out = 4'h6;
      2'h2: alt_gain_x4_out = 4'h4;
      default: alt_gain_x4_out = 4'h2;
    endcase
    case (alt_cfg_in[`ALT_TIME_MSB:`ALT_TIME_LSB])
      3'h0: alt_time_ns_out = 15'h00fa;
      3'h1: alt_time_ns_out = 15'h03e8;
      3'h2: alt_time_ns_out = 15'h0bb8;
      3'h3: alt_time_ns_out = 15'h1194;
      3'h4: alt_time_ns_out = 15'h186a;
      3'h5: alt_time_ns_out = 15'h1f40;
      3'h6: alt_time_ns_out = 15'h2710;
      default: alt_time_ns_out = 15'h4e20;
    endcase
    case (alt_cfg_in[`ALT_RAMP_MSB:`ALT_RAMP_LSB])
      3'h0: alt_ramp_mv_out = 8'h28;
      3'h1: alt_ramp_mv_out = 8'h3c;
      3'h2: alt_ramp_mv_out = 8'h50;
      3'h3: alt_ramp_mv_out = 8'h64;
      3'h4: alt_ramp_mv_out = 8'h78;
      3'h5: alt_ramp_mv_out = 8'ha0;
      3'h6: alt_ramp_mv_out = 8'hc8;
      default: alt_ramp_mv_out = 8'hf0;
    endcase
  end
endmodule

/* File: loop_compensation_cfg_regs.sv */
`timescale 1ns/100ps
`include "loop_cfg_params.svh"
module loop_compensation_cfg_regs #(
  parameter int DATA_W = 8
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic wr_strobe_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_strobe_in,
  input wire logic nvm_load_in,
  input wire logic [7:0] nvm_alt_cfg_in,
  input wire logic [7:0] nvm_loop_cfg_in,
  input wire logic softstart_active_in,
  input wire logic forced_continuous_conduction_in,
  input wire logic [1:0] vid_protocol_identifier_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic cmd_ack_out,
  output logic discontinuous_conduction_out,
  output logic forced_continuous_conduction_out,
  output logic [11:0] noc_numer_mv_out,
  output logic [8:0] sense_inductor_nh_out,
  output logic [12:0] dc_load_line_uohm_out,
  output logic [3:0] alt_gain_x4_out,
  output logic [14:0] alt_time_ns_out,
  output logic [7:0] alt_ramp_mv_out
);
  loop_cfg_pkg::cfg_state_t state_q;
  loop_cfg_pkg::cfg_state_t state_d;
  logic [11:0] dec_numer;
  logic [8:0] dec_ind;
  logic [12:0] dec_dc_load_line_sel;
  logic [3:0] dec_gain;
  logic [14:0] dec_time;
  logic [7:0] dec_ramp;
  logic hit_alt;
  logic hit_loop;

  // the command interface carries single bytes only, refused at elaboration
  if (DATA_W != 8) begin : g_width_check
    $error("loop_compensation_cfg_regs serves 8-bit data only");
  end

  // decoding of the stored fields
  loop_setting_decode u_decode (
    .alt_cfg_in(state_q.alt_cfg),
    .loop_cfg_in(state_q.loop_cfg),
    .vid_protocol_identifier_in(vid_protocol_identifier_in),
    .noc_numer_mv_out(dec_numer),
    .ind_nh_out(dec_ind),
    .dc_load_line_sel_uohm_out(dec_dc_load_line_sel),
    .alt_gain_x4_out(dec_gain),
    .alt_time_ns_out(dec_time),
    .alt_ramp_mv_out(dec_ramp)
  );

  assign hit_alt = (cmd_code_in == `ALT_CFG_OFFSET);
  assign hit_loop = (cmd_code_in == `LOOP_CFG_OFFSET);

  // next state: nvm load, host byte access, decoded outputs
  always_comb begin
    state_d = state_q;
    state_d.rd_valid = 1'b0;
    state_d.cmd_ack = 1'b0;
    if (nvm_load_in) begin
      state_d.alt_cfg = nvm_alt_cfg_in;
      state_d.loop_cfg = nvm_loop_cfg_in & `LOOP_WRITE_MASK;
    end
    if (wr_strobe_in) begin
      state_d.cmd_ack = hit_alt | hit_loop;
      if (hit_alt) begin
        state_d.alt_cfg = wr_data_in;
      end
      if (hit_loop) begin
        state_d.loop_cfg = wr_data_in & `LOOP_WRITE_MASK;
      end
    end else if (rd_strobe_in) begin
      state_d.rd_valid = 1'b1;
      state_d.cmd_ack = hit_alt | hit_loop;
      if (hit_alt) begin
        state_d.rd_data = state_q.alt_cfg;
      end else if (hit_loop) begin
        state_d.rd_data = state_q.loop_cfg;
      end else begin
        state_d.rd_data = 8'h00;
      end
    end
    // conduction mode: soft-start bit only counts while ramping
    if (softstart_active_in && state_q.loop_cfg[`SS_DCM_BIT]) begin
      state_d.ss_dcm_force = 1'b1;
      state_d.forced_continuous_conduction = 1'b0;
    end else begin
      state_d.ss_dcm_force = 1'b0;
      state_d.forced_continuous_conduction = forced_continuous_conduction_in;
    end
    state_d.noc_numer_mv = dec_numer;
    state_d.ind_nh = dec_ind;
    state_d.dc_load_line_sel_uohm = dec_dc_load_line_sel;
    state_d.alt_gain_x4 = dec_gain;
    state_d.alt_time_ns = dec_time;
    state_d.alt_ramp_mv = dec_ramp;
  end

  // state register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= '0;
      state_q.alt_cfg <= `ALT_CFG_RESET;
      state_q.loop_cfg <= `LOOP_CFG_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state word
  assign rd_data_out = state_q.rd_data;
  assign rd_valid_out = state_q.rd_valid;
  assign cmd_ack_out = state_q.cmd_ack;
  assign discontinuous_conduction_out = state_q.ss_dcm_force;
  assign forced_continuous_conduction_out = state_q.forced_continuous_conduction;
  assign noc_numer_mv_out = state_q.noc_numer_mv;
  assign sense_inductor_nh_out = state_q.ind_nh;
  assign dc_load_line_uohm_out = state_q.dc_load_line_sel_uohm;
  assign alt_gain_x4_out = state_q.alt_gain_x4;
  assign alt_time_ns_out = state_q.alt_time_ns;
  assign alt_ramp_mv_out = state_q.alt_ramp_mv;

  // assertions run on the core clock, quiet during reset
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  // host accesses as the assertions see them
  sequence s_alt_write;
    wr_strobe_in && hit_alt && !nvm_load_in;
  endsequence
  sequence s_alt_read;
    rd_strobe_in && !wr_strobe_in && hit_alt;
  endsequence
  sequence s_loop_write;
    wr_strobe_in && hit_loop && !nvm_load_in;
  endsequence
  sequence s_unmapped_read;
    rd_strobe_in && !wr_strobe_in && !hit_alt && !hit_loop;
  endsequence

  a_alt_readback: assert property (s_alt_write ##1 (s_alt_read and (!wr_strobe_in && !nvm_load_in))
    |=> rd_valid_out && rd_data_out == $past(wr_data_in, 2))
    else $error("alternate byte readback differs from written value");

  a_alt_gain_map: assert property (state_q.alt_cfg[7:6] == 2'h1 |=> alt_gain_x4_out == 4'h6)
    else $error("alternate gain code 01b not 1.5");

  a_alt_time_map: assert property (state_q.alt_cfg[5:3] == 3'h7 |=> alt_time_ns_out == 15'h4e20)
    else $error("alternate time code 111b not 20 us");

  a_alt_ramp_map: assert property (state_q.alt_cfg[2:0] == 3'h0 |=> alt_ramp_mv_out == 8'h28)
    else $error("alternate ramp code 000b not 40 mv");

  a_reserved_bit_zero: assert property (rd_strobe_in && !wr_strobe_in && hit_loop |=> !rd_data_out[7])
    else $error("reserved loop bit reads nonzero");

  a_softstart_dcm: assert property (softstart_active_in && state_q.loop_cfg[6]
    |=> discontinuous_conduction_out && !forced_continuous_conduction_out)
    else $error("soft-start discontinuous force missing");

  a_after_ramp_free: assert property (!softstart_active_in
    |=> !discontinuous_conduction_out && forced_continuous_conduction_out == $past(forced_continuous_conduction_in))
    else $error("soft-start bit acts after ramp");

  a_noc_5mv_step: assert property ((vid_protocol_identifier_in == 2'h1) && state_q.loop_cfg[5]
    |=> noc_numer_mv_out == `NOC_SHORT_5MV_MV)
    else $error("short on-time numerator wrong at 5 mv steps");

  a_noc_10mv_step: assert property ((vid_protocol_identifier_in == 2'h3) && !state_q.loop_cfg[5]
    |=> noc_numer_mv_out == `NOC_LONG_10MV_MV)
    else $error("long on-time numerator wrong at 10 mv steps");

  a_inductor_map: assert property (state_q.loop_cfg[4:3] == 2'h3 |=> sense_inductor_nh_out == 9'h190)
    else $error("inductor code 11b not 400 nh");

  a_load_line_flat: assert property (state_q.loop_cfg[2:0] == 3'h0 |=> dc_load_line_uohm_out == 13'h0000)
    else $error("load line code 000b not flat");

  a_loop_write_live: assert property (wr_strobe_in && hit_loop |=> ##1
    sense_inductor_nh_out == ((9'h064) * ($past(wr_data_in[4:3], 2) + 9'h001)))
    else $error("loop write did not take effect");

  a_write_ack_pulse: assert property (wr_strobe_in && (hit_alt || hit_loop) |=> cmd_ack_out && !rd_valid_out)
    else $error("mapped write not acknowledged");

  a_write_blocks_read: assert property (wr_strobe_in |=> !rd_valid_out)
    else $error("read answered while a write was taken");

  a_unmapped_read_zero: assert property (s_unmapped_read
    |=> rd_valid_out && !cmd_ack_out && rd_data_out == 8'h00)
    else $error("unmapped read not answered with zero");

  a_loop_write_mask: assert property (s_loop_write
    |=> !state_q.loop_cfg[7] && state_q.loop_cfg[6:0] == $past(wr_data_in[6:0]))
    else $error("loop byte write not stored with bit 7 clear");

  a_nvm_load_apply: assert property (nvm_load_in && !wr_strobe_in
    |=> state_q.alt_cfg == $past(nvm_alt_cfg_in) && state_q.loop_cfg == {1'b0, $past(nvm_loop_cfg_in[6:0])})
    else $error("nvm image not loaded");

  a_alt_steers_none: assert property (s_alt_write
    |=> ##1 $stable(sense_inductor_nh_out) && $stable(dc_load_line_uohm_out))
    else $error("alternate byte write moved a loop output");

  a_softstart_bit_clear: assert property (softstart_active_in && !state_q.loop_cfg[6]
    |=> !discontinuous_conduction_out && forced_continuous_conduction_out == $past(forced_continuous_conduction_in))
    else $error("ramp ignores forced-continuous setting");

  a_noc_5mv_long: assert property ((vid_protocol_identifier_in == 2'h2) && !state_q.loop_cfg[5]
    |=> noc_numer_mv_out == `NOC_LONG_5MV_MV)
    else $error("long on-time numerator wrong at 5 mv steps");

  a_noc_10mv_short: assert property ((vid_protocol_identifier_in == 2'h0) && state_q.loop_cfg[5]
    |=> noc_numer_mv_out == `NOC_SHORT_10MV_MV)
    else $error("short on-time numerator wrong at 10 mv steps");
endmodule

/* File: host_byte_model.sv */
`timescale 1ns/100ps
module host_byte_model (
  input wire logic clock_in,
  output logic [7:0] cmd_code_out,
  output logic wr_strobe_out,
  output logic [7:0] wr_data_out,
  output logic rd_strobe_out
);
  // idle levels from time zero
  initial begin
    cmd_code_out = 8'h00;
    wr_strobe_out = 1'h0;
    wr_data_out = 8'h00;
    rd_strobe_out = 1'h0;
  end
  // one byte written, strobe held up to the taking edge
  task automatic write_byte(input logic [7:0] code, input logic [7:0] data);
    @(posedge clock_in);
    cmd_code_out <= code;
    wr_data_out <= data;
    wr_strobe_out <= 1'h1;
    @(posedge clock_in);
    wr_strobe_out <= 1'h0;
    cmd_code_out <= ~code; // released lines show no stale value
    wr_data_out <= ~data;
  endtask
  // one byte read request
  task automatic read_byte(input logic [7:0] code);
    @(posedge clock_in);
    cmd_code_out <= code;
    rd_strobe_out <= 1'h1;
    @(posedge clock_in);
    rd_strobe_out <= 1'h0;
    cmd_code_out <= ~code;
  endtask
  // write then read the same code on the very next edge, no idle cycle
  task automatic write_then_read(input logic [7:0] code, input logic [7:0] data);
    @(posedge clock_in);
    cmd_code_out <= code;
    wr_data_out <= data;
    wr_strobe_out <= 1'h1;
    @(posedge clock_in);
    wr_strobe_out <= 1'h0;
    wr_data_out <= ~data;
    rd_strobe_out <= 1'h1;
    @(posedge clock_in);
    rd_strobe_out <= 1'h0;
    cmd_code_out <= ~code;
  endtask
  // nearest inductor code, top code for anything above 350 nH
  function automatic logic [1:0] ind_code(input int nh);
    return (nh <= 150) ? 2'h0 : (nh <= 250) ? 2'h1 : (nh <= 350) ? 2'h2 : 2'h3;
  endfunction
endmodule

/* File: loop_compensation_cfg_regs_test.sv */
`timescale 1ns/100ps
module loop_compensation_cfg_regs_test;
  typedef struct {
    logic [7:0] alt;
    logic [7:0] loop;
    logic [3:0] gain;
    logic [14:0] time_ns;
    logic [7:0] ramp;
    logic [8:0] ind;
    logic [12:0] dc_load_line_sel;
  } row_t;
  logic clock_in = 1'h0;
  logic rstn;
  logic [7:0] cmd_code;
  logic wr_strobe;
  logic [7:0] wr_data;
  logic rd_strobe;
  logic nvm_load = 1'h0;
  logic [7:0] nvm_alt = 8'h00;
  logic [7:0] nvm_loop = 8'h00;
  logic softstart = 1'h0;
  logic forced_continuous_conduction_cfg = 1'h0;
  logic [1:0] protocol = 2'h0;
  logic [7:0] rd_data;
  logic rd_valid, cmd_ack, discontinuous_conduction, forced_continuous_conduction;
  logic [11:0] noc;
  logic [8:0] ind_nh;
  logic [12:0] dc_load_line_sel;
  logic [3:0] gain;
  logic [14:0] time_ns;
  logic [7:0] ramp;
  int failures = 0;
  int checked = 0;
  // written bytes beside the decodes they should give
  row_t rows [8] = '{
    '{8'h00, 8'h80, 4'h8, 15'h00fa, 8'h28, 9'h064, 13'h0000},
    '{8'h49, 8'ha9, 4'h6, 15'h03e8, 8'h3c, 9'h0c8, 13'h01f4},
    '{8'h92, 8'hd2, 4'h4, 15'h0bb8, 8'h50, 9'h12c, 13'h02ee},
    '{8'hdb, 8'h7b, 4'h2, 15'h1194, 8'h64, 9'h190, 13'h03e8},
    '{8'h24, 8'ha4, 4'h8, 15'h186a, 8'h78, 9'h064, 13'h05dc},
    '{8'h6d, 8'h0d, 4'h6, 15'h1f40, 8'ha0, 9'h0c8, 13'h0b54},
    '{8'hb6, 8'hf6, 4'h4, 15'h2710, 8'hc8, 9'h12c, 13'h0c80},
    '{8'hff, 8'h9f, 4'h2, 15'h4e20, 8'hf0, 9'h190, 13'h0fd2}};

  always #10 clock_in = ~clock_in;

  host_byte_model i_host_byte_model (.clock_in(clock_in), .cmd_code_out(cmd_code), .wr_strobe_out(wr_strobe),
    .wr_data_out(wr_data), .rd_strobe_out(rd_strobe));

  loop_compensation_cfg_regs i_loop_compensation_cfg_regs (.clock_in(clock_in), .rstn_in(rstn),
    .cmd_code_in(cmd_code), .wr_strobe_in(wr_strobe), .wr_data_in(wr_data), .rd_strobe_in(rd_strobe),
    .nvm_load_in(nvm_load), .nvm_alt_cfg_in(nvm_alt), .nvm_loop_cfg_in(nvm_loop),
    .softstart_active_in(softstart), .forced_continuous_conduction_in(forced_continuous_conduction_cfg),
    .vid_protocol_identifier_in(protocol), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .cmd_ack_out(cmd_ack), .discontinuous_conduction_out(discontinuous_conduction), .forced_continuous_conduction_out(forced_continuous_conduction),
    .noc_numer_mv_out(noc), .sense_inductor_nh_out(ind_nh), .dc_load_line_uohm_out(dc_load_line_sel),
    .alt_gain_x4_out(gain), .alt_time_ns_out(time_ns), .alt_ramp_mv_out(ramp));

  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // write, then look at the answer cycle
  task automatic wr_chk(input logic [7:0] code, input logic [7:0] data, input logic ack);
    i_host_byte_model.write_byte(code, data);
    #1;
    check(cmd_ack, ack, "write ack");
  endtask

  // read, then look at the answer cycle
  task automatic read_chk(input logic [7:0] code, input logic [7:0] exp, input logic ack);
    i_host_byte_model.read_byte(code);
    #1;
    check(rd_valid, 16'h0001, "read valid");
    check(cmd_ack, ack, "read ack");
    check(rd_data, exp, "read data");
  endtask

  // main sequence
  initial begin
    rstn <= 1'h0;
    repeat (4) @(posedge clock_in);
    rstn <= 1'h1;
    read_chk(8'hac, 8'h00, 1'h1);
    read_chk(8'had, 8'h00, 1'h1);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      softstart <= i[0];
      forced_continuous_conduction_cfg <= i[1];
      protocol <= i[1:0];
      wr_chk(8'hac, rows[i].alt, 1'h1);
      wr_chk(8'had, rows[i].loop, 1'h1);
      read_chk(8'hac, rows[i].alt, 1'h1);
      read_chk(8'had, rows[i].loop & 8'h7f, 1'h1);
      check(gain, rows[i].gain, "gain");
      check(time_ns, rows[i].time_ns, "time");
      check(ramp, rows[i].ramp, "ramp");
      check(ind_nh, rows[i].ind, "inductor");
      check(dc_load_line_sel, rows[i].dc_load_line_sel, "load line");
      check(discontinuous_conduction, i[0] & rows[i].loop[6], "dcm");
      check(forced_continuous_conduction, i[1] & ~(i[0] & rows[i].loop[6]), "forced_continuous_conduction");
      check(noc, rows[i].loop[5] ? ((i[0] ^ i[1]) ? 16'h0258 : 16'h04b0)
        : ((i[0] ^ i[1]) ? 16'h0640 : 16'h0c80), "on-time");
    end
    $display("test decode rows done");
    wr_chk(8'hae, 8'h55, 1'h0);
    read_chk(8'hae, 8'h00, 1'h0);
    @(posedge clock_in);
    nvm_alt <= 8'h5a;
    nvm_loop <= 8'hff;
    nvm_load <= 1'h1;
    @(posedge clock_in);
    nvm_load <= 1'h0;
    read_chk(8'hac, 8'h5a, 1'h1);
    read_chk(8'had, 8'h7f, 1'h1);
    wr_chk(8'hac, 8'h00, 1'h1);
    @(posedge clock_in);
    #1;
    check(dc_load_line_sel, 16'h0fd2, "load line kept");
    check(ind_nh, 16'h0190, "inductor kept");
    i_host_byte_model.write_then_read(8'hac, 8'hc3);
    #1;
    check(rd_valid, 16'h0001, "back to back valid");
    check(rd_data, 16'h00c3, "back to back data");
    $display("test unmapped and nvm done");
    wr_chk(8'had, {3'h0, i_host_byte_model.ind_code(180), 3'h0}, 1'h1);
    @(posedge clock_in);
    #1;
    check(ind_nh, 16'h00c8, "inductor near");
    check(dc_load_line_sel, 16'h0000, "flat line");
    wr_chk(8'had, {3'h0, i_host_byte_model.ind_code(470), 3'h0}, 1'h1);
    @(posedge clock_in);
    #1;
    check(ind_nh, 16'h0190, "inductor top");
    @(posedge clock_in);
    rstn <= 1'h0;
    repeat (2) @(posedge clock_in);
    rstn <= 1'h1;
    read_chk(8'had, 8'h00, 1'h1);
    check(ind_nh, 16'h0064, "inductor after reset");
    check(dc_load_line_sel, 16'h0000, "load line after reset");
    $display("test inductor and mid reset done");
    summarize();
  end

  // watchdog: tests need about a hundred cycles, this allows ten thousand
  initial begin
    #200000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
